// file: itfm_top.v
// Multi-function input terminal map with AHB-Lite register slave
`timescale 1ns/10ps
`include "itfm_map.vh"
module itfm_top #(
   parameter RAMP_TICK_CYCLES = `ITFM_RAMP_TICK_NS / `ITFM_CLK_PERIOD_NS
) (
   clk_sys,
   resetn,
   clkEn,
   inputTerminalOne,
   inputTerminalTwo,
   inputTerminalThree,
   inputTerminalFour,
   analogInputAsDigital,
   inverterRunning,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hrdata,
   hreadyout,
   hresp,
   runCmd,
   reverseCmd,
   stopCmd,
   jogForward,
   jogReverse,
   jogDecelStop,
   outputBlock,
   finalFreq
);
   input  wire        clk_sys;
   input  wire        resetn;
   input  wire        clkEn;
   input  wire        inputTerminalOne;
   input  wire        inputTerminalTwo;
   input  wire        inputTerminalThree;
   input  wire        inputTerminalFour;
   input  wire        analogInputAsDigital;
   input  wire        inverterRunning;
   input  wire        hsel;
   input  wire [31:0] haddr;
   input  wire [1:0]  htrans;
   input  wire        hwrite;
   input  wire [2:0]  hsize;
   input  wire [31:0] hwdata;
   input  wire        hready;
   output reg  [31:0] hrdata;
   output reg         hreadyout;
   output reg         hresp;
   output reg         runCmd;
   output reg         reverseCmd;
   output reg         stopCmd;
   output reg         jogForward;
   output reg         jogReverse;
   output reg         jogDecelStop;
   output reg         outputBlock;
   output reg  [15:0] finalFreq;

   // Software-visible state
   reg  [15:0] selOne_q;
   reg  [15:0] selTwo_q;
   reg  [15:0] selThree_q;
   reg  [15:0] selFour_q;
   reg  [15:0] selAnalog_q;
   reg  [`ITFM_CTRL_WIDTH-1:0] ctrl_q;
   reg  [15:0] rampRate_q;
   reg  [15:0] mainFreq_q;

   // Bus data phase state
   reg         wrPend_q;
   reg         rdPend_q;
   reg  [13:0] wordIdx_q;
   reg         inRange_q;

   // Three-line run latch and previous run level
   reg         runLatch_q;
   reg         runPrev_q;

   wire [4:0]  snap;
   wire [`ITFM_FN_COUNT-1:0] fnAct;
   wire [15:0] offsetFreq;
   wire        termSrc;
   wire [1:0]  ctlMode;
   wire        threeLine;
   wire        revInhibit;
   wire        mainInvolved;
   wire        addrAccept;
   wire [17:0] finalSum;
   reg  [31:0] rdValue;
   reg         runNext;
   reg         revNext;

   // Synchronised snapshot of all five inputs
   itfm_input_sync uSync (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .clkEn    (clkEn),
      .pinIn    ({analogInputAsDigital, inputTerminalFour, inputTerminalThree,
                  inputTerminalTwo, inputTerminalOne}),
      .levelOut (snap)
   );

   // Function decode: OR of every input whose code matches
   assign fnAct[`ITFM_FN_NONE] = 1'b0;
   genvar f;
   generate
      for (f = 1; f < `ITFM_FN_COUNT; f = f + 1) begin : gFn
         localparam [15:0] CODE = f;
         assign fnAct[f] = (snap[0] && selOne_q    == CODE) ||
                           (snap[1] && selTwo_q    == CODE) ||
                           (snap[2] && selThree_q  == CODE) ||
                           (snap[3] && selFour_q   == CODE) ||
                           (snap[4] && selAnalog_q == CODE);
      end
   endgenerate

   assign termSrc      = (ctrl_q[`ITFM_CTRL_SRC_MSB:`ITFM_CTRL_SRC_LSB] == `ITFM_SRC_TERMINAL);
   assign ctlMode      = ctrl_q[`ITFM_CTRL_MODE_MSB:`ITFM_CTRL_MODE_LSB];
   assign threeLine    = (ctlMode == `ITFM_MODE_THREE_LINE_A) ||
                         (ctlMode == `ITFM_MODE_THREE_LINE_B);
   assign revInhibit   = ctrl_q[`ITFM_CTRL_REV_INHIBIT];
   assign mainInvolved = ctrl_q[`ITFM_CTRL_MAIN_INVOLVED];

   // Offset accumulator
   itfm_offset_acc #(
      .TICK_CYCLES (RAMP_TICK_CYCLES)
   ) uOffset (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .clkEn    (clkEn),
      .enable   (mainInvolved),
      .upReq    (fnAct[`ITFM_FN_UP]),
      .downReq  (fnAct[`ITFM_FN_DOWN]),
      .clearReq (fnAct[`ITFM_FN_CLEAR]),
      .rate     (rampRate_q),
      .offset   (offsetFreq)
   );

   // Main set frequency plus signed offset; two guard bits keep full range
   assign finalSum = {2'b00, mainFreq_q} + {{2{offsetFreq[15]}}, offsetFreq};

   // Run and direction per terminal control mode
   always @* begin
      runNext = 1'b0;
      revNext = 1'b0;
      if (termSrc) begin
         case (ctlMode)
            `ITFM_MODE_TWO_LINE_A: begin
               runNext = fnAct[`ITFM_FN_RUN];
               revNext = fnAct[`ITFM_FN_DIR];
            end
            `ITFM_MODE_TWO_LINE_B: begin
               runNext = fnAct[`ITFM_FN_RUN] ^ fnAct[`ITFM_FN_DIR];
               revNext = fnAct[`ITFM_FN_DIR] && !fnAct[`ITFM_FN_RUN];
            end
            `ITFM_MODE_THREE_LINE_A,
            `ITFM_MODE_THREE_LINE_B: begin
               runNext = runLatch_q && !fnAct[`ITFM_FN_STOP3];
               revNext = fnAct[`ITFM_FN_DIR];
            end
            default: begin
               runNext = 1'b0;
               revNext = 1'b0;
            end
         endcase
      end
   end

   // Three-line run latch: run edge sets, stop input clears and wins
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         runLatch_q <= 1'b0;
         runPrev_q  <= 1'b0;
      end else if (clkEn) begin
         runPrev_q <= fnAct[`ITFM_FN_RUN];
         if (!termSrc || !threeLine || fnAct[`ITFM_FN_STOP3]) begin
            runLatch_q <= 1'b0;
         end else if (fnAct[`ITFM_FN_RUN] && !runPrev_q) begin
            runLatch_q <= 1'b1;
         end
      end
   end

   // Registered command outputs
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         runCmd       <= 1'b0;
         reverseCmd   <= 1'b0;
         stopCmd      <= 1'b0;
         jogForward   <= 1'b0;
         jogReverse   <= 1'b0;
         jogDecelStop <= 1'b0;
         outputBlock  <= 1'b0;
         finalFreq    <= 16'h0000;
      end else if (clkEn) begin
         runCmd     <= runNext;
         reverseCmd <= revNext;
         stopCmd    <= termSrc && threeLine && fnAct[`ITFM_FN_STOP3];
         // Reverse jog dropped when reverse is prohibited
         jogForward   <= termSrc && fnAct[`ITFM_FN_JOG_FWD] &&
                         !(fnAct[`ITFM_FN_JOG_REV] && !revInhibit);
         jogReverse   <= termSrc && fnAct[`ITFM_FN_JOG_REV] && !revInhibit &&
                         !fnAct[`ITFM_FN_JOG_FWD];
         jogDecelStop <= termSrc && fnAct[`ITFM_FN_JOG_FWD] &&
                         fnAct[`ITFM_FN_JOG_REV] && !revInhibit;
         // Block holds until the drive reports stopped; set wins
         if (fnAct[`ITFM_FN_COAST] && inverterRunning) begin
            outputBlock <= 1'b1;
         end else if (!inverterRunning) begin
            outputBlock <= 1'b0;
         end
         // Floored at zero, capped at full scale
         finalFreq <= finalSum[17] ? 16'h0000 :
                      (finalSum[16] ? 16'hffff : finalSum[15:0]);
      end
   end

   // Address phase accepted
   assign addrAccept = hsel && hready && htrans[1];

   // Read mux on the captured word index
   always @* begin
      rdValue = 32'h0000_0000;
      if (inRange_q) begin
         case (wordIdx_q)
            `ITFM_IDX_SEL_ONE:    rdValue = {16'h0000, selOne_q};
            `ITFM_IDX_SEL_TWO:    rdValue = {16'h0000, selTwo_q};
            `ITFM_IDX_SEL_THREE:  rdValue = {16'h0000, selThree_q};
            `ITFM_IDX_SEL_FOUR:   rdValue = {16'h0000, selFour_q};
            `ITFM_IDX_SEL_ANALOG: rdValue = {16'h0000, selAnalog_q};
            `ITFM_IDX_CTRL:       rdValue = {26'h000_0000, ctrl_q};
            `ITFM_IDX_RAMP:       rdValue = {16'h0000, rampRate_q};
            `ITFM_IDX_MAIN_FREQ:  rdValue = {16'h0000, mainFreq_q};
            `ITFM_IDX_OFFSET_MON: rdValue = {16'h0000, offsetFreq};
            `ITFM_IDX_FINAL_FREQ: rdValue = {16'h0000, finalFreq};
            `ITFM_IDX_STATUS:     rdValue = {17'h0_0000, outputBlock, snap,
                                             fnAct[`ITFM_FN_COUNT-1:1]};
            default:              rdValue = 32'h0000_0000;
         endcase
      end
   end

   // AHB-Lite slave: zero-wait writes, one wait state on reads
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend_q  <= 1'b0;
         rdPend_q  <= 1'b0;
         wordIdx_q <= 14'h0000;
         inRange_q <= 1'b0;
      end else if (clkEn) begin
         hresp <= 1'b0;
         if (rdPend_q) begin
            hrdata    <= rdValue;
            hreadyout <= 1'b1;
            rdPend_q  <= 1'b0;
         end else if (hreadyout) begin
            wrPend_q <= addrAccept && hwrite;
            if (addrAccept) begin
               wordIdx_q <= haddr[15:2];
               inRange_q <= (haddr[31:16] == 16'h0000);
            end
            if (addrAccept && !hwrite) begin
               rdPend_q  <= 1'b1;
               hreadyout <= 1'b0;
            end
         end
      end
   end

   // Register writes in the data phase
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         selOne_q    <= `ITFM_RST_SEL_ONE;
         selTwo_q    <= `ITFM_RST_SEL_TWO;
         selThree_q  <= `ITFM_RST_SEL_THREE;
         selFour_q   <= `ITFM_RST_SEL_FOUR;
         selAnalog_q <= `ITFM_RST_SEL_ANALOG;
         ctrl_q      <= `ITFM_RST_CTRL;
         rampRate_q  <= `ITFM_RST_RAMP;
         mainFreq_q  <= `ITFM_RST_MAIN_FREQ;
      end else if (clkEn && wrPend_q && inRange_q) begin
         case (wordIdx_q)
            `ITFM_IDX_SEL_ONE:    selOne_q    <= hwdata[15:0];
            `ITFM_IDX_SEL_TWO:    selTwo_q    <= hwdata[15:0];
            `ITFM_IDX_SEL_THREE:  selThree_q  <= hwdata[15:0];
            `ITFM_IDX_SEL_FOUR:   selFour_q   <= hwdata[15:0];
            `ITFM_IDX_SEL_ANALOG: selAnalog_q <= hwdata[15:0];
            `ITFM_IDX_CTRL:       ctrl_q      <= hwdata[`ITFM_CTRL_WIDTH-1:0];
            `ITFM_IDX_RAMP:       rampRate_q  <= hwdata[15:0];
            `ITFM_IDX_MAIN_FREQ:  mainFreq_q  <= hwdata[15:0];
            default:              ctrl_q      <= ctrl_q;
         endcase
      end
   end
endmodule

// file: itfm_map.vh
// Register indices, field positions, reset values and timing for the input function map
`ifndef ITFM_MAP_VH
`define ITFM_MAP_VH

// Register word indices; byte address is four times the index
`define ITFM_IDX_SEL_ONE        14'h0200
`define ITFM_IDX_SEL_TWO        14'h0201
`define ITFM_IDX_SEL_THREE      14'h0202
`define ITFM_IDX_SEL_FOUR       14'h0203
`define ITFM_IDX_SEL_ANALOG     14'h0207
`define ITFM_IDX_CTRL           14'h0000
`define ITFM_IDX_RAMP           14'h0001
`define ITFM_IDX_MAIN_FREQ      14'h0002
`define ITFM_IDX_OFFSET_MON     14'h0003
`define ITFM_IDX_FINAL_FREQ     14'h0004
`define ITFM_IDX_STATUS         14'h0005

// Register reset values
`define ITFM_RST_SEL_ONE        16'h0001
`define ITFM_RST_SEL_TWO        16'h0002
`define ITFM_RST_SEL_THREE      16'h000b
`define ITFM_RST_SEL_FOUR       16'h000c
`define ITFM_RST_SEL_ANALOG     16'h0000
`define ITFM_RST_CTRL           6'h00
`define ITFM_RST_RAMP           16'h0001
`define ITFM_RST_MAIN_FREQ      16'h0000

// Control register fields
`define ITFM_CTRL_SRC_LSB       0
`define ITFM_CTRL_SRC_MSB       1
`define ITFM_CTRL_MODE_LSB      2
`define ITFM_CTRL_MODE_MSB      3
`define ITFM_CTRL_REV_INHIBIT   4
`define ITFM_CTRL_MAIN_INVOLVED 5
`define ITFM_CTRL_WIDTH         6

// Field values
`define ITFM_SRC_TERMINAL       2'h1
`define ITFM_MODE_TWO_LINE_A    2'h0
`define ITFM_MODE_TWO_LINE_B    2'h1
`define ITFM_MODE_THREE_LINE_A  2'h2
`define ITFM_MODE_THREE_LINE_B  2'h3

// Function codes
`define ITFM_FN_NONE            0
`define ITFM_FN_RUN             1
`define ITFM_FN_DIR             2
`define ITFM_FN_STOP3           3
`define ITFM_FN_JOG_FWD         4
`define ITFM_FN_JOG_REV         5
`define ITFM_FN_UP              6
`define ITFM_FN_DOWN            7
`define ITFM_FN_CLEAR           8
`define ITFM_FN_COAST           9
`define ITFM_FN_COUNT           10

// Offset ramp step period, in ns, and the clock period
`define ITFM_RAMP_TICK_NS       1000000
`define ITFM_CLK_PERIOD_NS      5

`endif

// file: itfm_input_sync.v
// Two-stage synchroniser for the terminal inputs
`timescale 1ns/10ps
module itfm_input_sync (
   clk_sys,
   resetn,
   clkEn,
   pinIn,
   levelOut
);
   input  wire       clk_sys;
   input  wire       resetn;
   input  wire       clkEn;
   input  wire [4:0] pinIn;
   output wire [4:0] levelOut;

   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : gSync
         reg stageOne_q;
         reg stageTwo_q;
         // First stage feeds only the second
         always @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               stageOne_q <= 1'b0;
               stageTwo_q <= 1'b0;
            end else if (clkEn) begin
               stageOne_q <= pinIn[g];
               stageTwo_q <= stageOne_q;
            end
         end
         assign levelOut[g] = stageTwo_q;
      end
   endgenerate
endmodule

// file: itfm_offset_acc.v
// Up/down frequency offset accumulator with ramp tick
`timescale 1ns/10ps
module itfm_offset_acc #(
   parameter TICK_CYCLES = 200000
) (
   clk_sys,
   resetn,
   clkEn,
   enable,
   upReq,
   downReq,
   clearReq,
   rate,
   offset
);
   input  wire        clk_sys;
   input  wire        resetn;
   input  wire        clkEn;
   input  wire        enable;
   input  wire        upReq;
   input  wire        downReq;
   input  wire        clearReq;
   input  wire [15:0] rate;
   output reg  [15:0] offset;

   reg  [31:0] tickCnt_q;
   wire        tick;
   wire [16:0] sumUp;
   wire [16:0] sumDown;
   wire [16:0] rateExt;

   assign tick    = (tickCnt_q == TICK_CYCLES - 1);
   assign rateExt = {1'b0, rate};
   assign sumUp   = {offset[15], offset} + rateExt;
   assign sumDown = {offset[15], offset} - rateExt;

   // Ramp step period
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tickCnt_q <= 32'h0000_0000;
      end else if (clkEn) begin
         tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
      end
   end

   // Clear first, then one ramp step, saturating at the signed limits
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         offset <= 16'h0000;
      end else if (clkEn && enable) begin
         if (clearReq) begin
            offset <= 16'h0000;
         end else if (tick && upReq && !downReq) begin
            offset <= (sumUp[16] != sumUp[15]) ? 16'h7fff : sumUp[15:0];
         end else if (tick && downReq && !upReq) begin
            offset <= (sumDown[16] != sumDown[15]) ? 16'h8000 : sumDown[15:0];
         end
      end
   end
endmodule

// file: itfm_switch_bank.sv
// Model of the external switches that drive the five terminals
`timescale 1ns/10ps
module itfm_switch_bank (
   input  wire logic       clk_sys,
   input  wire logic [4:0] wantLevel,
   output logic            pinOne,
   output logic            pinTwo,
   output logic            pinThree,
   output logic            pinFour,
   output logic            pinAnalog
);
   // Contacts settle just after a clock edge, never on it
   initial {pinAnalog, pinFour, pinThree, pinTwo, pinOne} = 5'h0;
   always @(posedge clk_sys) begin
      {pinAnalog, pinFour, pinThree, pinTwo, pinOne} <= #1 wantLevel;
   end
endmodule

// file: itfm_top_sva.sv
// Checker for the input function map, bound to the top module
`timescale 1ns/10ps
module itfm_top_sva (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        clkEn,
   input wire logic        inputTerminalOne,
   input wire logic        inputTerminalTwo,
   input wire logic        inputTerminalThree,
   input wire logic        inputTerminalFour,
   input wire logic        analogInputAsDigital,
   input wire logic        inverterRunning,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        runCmd,
   input wire logic        reverseCmd,
   input wire logic        stopCmd,
   input wire logic        jogForward,
   input wire logic        jogReverse,
   input wire logic        jogDecelStop,
   input wire logic        outputBlock,
   input wire logic [15:0] finalFreq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic taken;
   logic pinsLow;
   // Accepted bus request and all-terminals-idle helpers
   assign taken   = hsel && hready && htrans[1] && clkEn && hreadyout;
   assign pinsLow = !(inputTerminalOne | inputTerminalTwo | inputTerminalThree
                      | inputTerminalFour | analogInputAsDigital);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave response not OKAY");
   a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait cycle");
   a_write_nowait: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_rdata_hold: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
      else $error("read data changed without a read");
   a_jog_exclusive: assert property (!(jogForward && jogReverse))
      else $error("forward and reverse jog together");
   a_coast_cause: assert property ($rose(outputBlock) |-> $past(inverterRunning))
      else $error("output blocked while not running");
   a_coast_release: assert property ($fell(outputBlock) |-> !$past(inverterRunning))
      else $error("output block dropped while running");
   a_idle_quiet: assert property ((pinsLow && clkEn) [*4]
      |-> !(jogForward | jogReverse | stopCmd | jogDecelStop))
      else $error("command active with every terminal idle");
   a_freeze_state: assert property (!clkEn |=> $stable(runCmd) && $stable(finalFreq)
      && $stable(outputBlock))
      else $error("state moved while clock enable low");
   cover property (taken && !hwrite);
   cover property ($rose(outputBlock));
endmodule

bind itfm_top itfm_top_sva i_sva (
   .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .inputTerminalOne(inputTerminalOne),
   .inputTerminalTwo(inputTerminalTwo), .inputTerminalThree(inputTerminalThree),
   .inputTerminalFour(inputTerminalFour), .analogInputAsDigital(analogInputAsDigital),
   .inverterRunning(inverterRunning), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .runCmd(runCmd), .reverseCmd(reverseCmd), .stopCmd(stopCmd), .jogForward(jogForward),
   .jogReverse(jogReverse), .jogDecelStop(jogDecelStop), .outputBlock(outputBlock),
   .finalFreq(finalFreq));

// file: input_terminal_function_map_tb_top.sv
// Self-checking bench for the input function map
`timescale 1ns/10ps
`include "itfm_map.vh"
module input_terminal_function_map_tb_top;
   logic clk_sys, resetn, clkEn, inverterRunning, hsel, hwrite;
   logic p1, p2, p3, p4, pA, hreadyout, hresp;
   logic [4:0] wantLevel;
   logic [31:0] haddr, hwdata, hrdata, rd, mon;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire [6:0] cmds;
   logic [15:0] finalFreq;
   int n_fail, n_compared, k;

   itfm_switch_bank i_sw (.clk_sys(clk_sys), .wantLevel(wantLevel), .pinOne(p1),
      .pinTwo(p2), .pinThree(p3), .pinFour(p4), .pinAnalog(pA));
   itfm_top #(.RAMP_TICK_CYCLES(8)) i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .inputTerminalOne(p1),
      .inputTerminalTwo(p2), .inputTerminalThree(p3), .inputTerminalFour(p4),
      .analogInputAsDigital(pA), .inverterRunning(inverterRunning), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .runCmd(cmds[6]), .reverseCmd(cmds[5]), .stopCmd(cmds[4]), .jogForward(cmds[3]),
      .jogReverse(cmds[2]), .jogDecelStop(cmds[1]), .outputBlock(cmds[0]),
      .finalFreq(finalFreq));

   // Clock at 200 MHz
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Byte address from a word index
   function automatic logic [31:0] ba(input logic [13:0] idx);
      return {16'h0000, idx, 2'b00};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t value %h expected %h", $time, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; address phase held until hready
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      // The wait ends once hreadyout is high; the watchdog catches a hang
      do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] d);
      xfer(1'b1, ba(idx), d);
   endtask

   task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
      xfer(1'b0, ba(idx), 32'h0000_0000);
      check(rd, exp);
   endtask

   task automatic sels(input logic [15:0] a, b, c, d, e);
      wr(`ITFM_IDX_SEL_ONE, {16'h0000, a});
      wr(`ITFM_IDX_SEL_TWO, {16'h0000, b});
      wr(`ITFM_IDX_SEL_THREE, {16'h0000, c});
      wr(`ITFM_IDX_SEL_FOUR, {16'h0000, d});
      wr(`ITFM_IDX_SEL_ANALOG, {16'h0000, e});
   endtask

   // Set terminal levels and let them pass the synchroniser
   task automatic pins(input logic [4:0] v, input int n);
      @(posedge clk_sys);
      wantLevel <= v;
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic cmdchk(input logic [6:0] exp);
      check({25'h0, cmds}, {25'h0, exp});
   endtask

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      test_done;
   end

   // Main sequence
   initial begin
      {resetn, hsel, hwrite, inverterRunning} = 4'h0;
      clkEn = 1'b1;
      wantLevel = 5'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'b00;
      hsize = 3'b010;
      n_fail = 0;
      n_compared = 0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rdchk(`ITFM_IDX_SEL_ONE, 32'h0000_0001);
      rdchk(`ITFM_IDX_SEL_TWO, 32'h0000_0002);
      rdchk(`ITFM_IDX_SEL_THREE, 32'h0000_000b);
      rdchk(`ITFM_IDX_SEL_FOUR, 32'h0000_000c);
      rdchk(`ITFM_IDX_SEL_ANALOG, 32'h0000_0000);
      rdchk(`ITFM_IDX_RAMP, 32'h0000_0001);
      wr(14'h0030, 32'h0000_5555);
      rdchk(14'h0030, 32'h0000_0000);
      wr(`ITFM_IDX_SEL_FOUR, 32'h0000_1234);
      rdchk(`ITFM_IDX_SEL_FOUR, 32'h0000_1234);
      // Every code on terminal one, seen through the status word
      for (k = 0; k < 12; k++) begin
         sels((k == 11) ? 16'h0022 : 16'(k), 16'h0000, 16'h0000, 16'h0000, 16'h0000);
         pins(5'b00001, 6);
         rdchk(`ITFM_IDX_STATUS, {17'h0, 5'b00001,
            (k >= 1 && k <= 9) ? 9'(1 << (k - 1)) : 9'h000});
      end
      // Run and direction under terminal source, mode 0
      wr(`ITFM_IDX_CTRL, 32'h0000_0021);
      sels(16'h0001, 16'h0002, 16'h0000, 16'h0001, 16'h0000);
      pins(5'b00001, 6);
      cmdchk(7'b1000000);
      pins(5'b00011, 6);
      cmdchk(7'b1100000);
      pins(5'b01100, 6);
      cmdchk(7'b1000000);
      wr(`ITFM_IDX_CTRL, 32'h0000_0020);
      pins(5'b01000, 6);
      cmdchk(7'b0000000);
      // Three-line stop only in a three-line mode
      wr(`ITFM_IDX_CTRL, 32'h0000_0029);
      sels(16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      pins(5'b00001, 6);
      cmdchk(7'b0010000);
      wr(`ITFM_IDX_CTRL, 32'h0000_0021);
      // New mode reaches the registered outputs one edge after the write
      repeat (2) @(posedge clk_sys);
      cmdchk(7'b0000000);
      // Jog, both together, reverse prohibited
      sels(16'h0004, 16'h0005, 16'h0000, 16'h0000, 16'h0000);
      pins(5'b00011, 6);
      cmdchk(7'b0000010);
      pins(5'b00010, 6);
      cmdchk(7'b0000100);
      wr(`ITFM_IDX_CTRL, 32'h0000_0031);
      pins(5'b00011, 6);
      cmdchk(7'b0001000);
      pins(5'b00010, 6);
      cmdchk(7'b0000000);
      // Coast stop, with a clock-enable pause in between
      wr(`ITFM_IDX_CTRL, 32'h0000_0021);
      sels(16'h0009, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      pins(5'b00001, 6);
      cmdchk(7'b0000000);
      inverterRunning <= 1'b1;
      clkEn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cmdchk(7'b0000000);
      clkEn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cmdchk(7'b0000001);
      inverterRunning <= 1'b0;
      repeat (3) @(posedge clk_sys);
      cmdchk(7'b0000000);
      // Offset up, down, clear and main-source gating
      wr(`ITFM_IDX_RAMP, 32'h0000_0005);
      wr(`ITFM_IDX_MAIN_FREQ, 32'h0000_03e8);
      sels(16'h0006, 16'h0007, 16'h0008, 16'h0000, 16'h0000);
      pins(5'b00001, 80);
      pins(5'b00000, 6);
      xfer(1'b0, ba(`ITFM_IDX_OFFSET_MON), 32'h0000_0000);
      mon = rd;
      check({31'h0, mon[15:0] != 0 && mon[15:0] % 5 == 0}, 32'h0000_0001);
      rdchk(`ITFM_IDX_FINAL_FREQ, {16'h0, 16'h03e8 + mon[15:0]});
      wr(`ITFM_IDX_CTRL, 32'h0000_0001);
      pins(5'b00001, 40);
      pins(5'b00000, 6);
      rdchk(`ITFM_IDX_OFFSET_MON, mon);
      wr(`ITFM_IDX_CTRL, 32'h0000_0021);
      pins(5'b00100, 6);
      pins(5'b00000, 6);
      rdchk(`ITFM_IDX_OFFSET_MON, 32'h0000_0000);
      pins(5'b00010, 40);
      pins(5'b00000, 6);
      xfer(1'b0, ba(`ITFM_IDX_OFFSET_MON), 32'h0000_0000);
      mon = rd;
      check({31'h0, mon[15]}, 32'h0000_0001);
      rdchk(`ITFM_IDX_FINAL_FREQ, {16'h0, 16'h03e8 + mon[15:0]});
      check({16'h0, finalFreq}, {16'h0, 16'h03e8 + mon[15:0]});
      // Mode 1: run is forward, direction is reverse, both mean stop
      wr(`ITFM_IDX_CTRL, 32'h0000_0025);
      sels(16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000);
      pins(5'b00001, 6);
      cmdchk(7'b1000000);
      pins(5'b00010, 6);
      cmdchk(7'b1100000);
      pins(5'b00011, 6);
      cmdchk(7'b0000000);
      // Three-line: run edge latches, stop input clears the latch
      wr(`ITFM_IDX_CTRL, 32'h0000_0029);
      sels(16'h0001, 16'h0003, 16'h0002, 16'h0000, 16'h0000);
      pins(5'b00000, 6);
      pins(5'b00001, 8);
      cmdchk(7'b1000000);
      pins(5'b00100, 8);
      cmdchk(7'b1100000);
      pins(5'b00010, 8);
      cmdchk(7'b0010000);
      test_done;
   end
endmodule
